// ### shared/mec_params.svh
/*
  Offsets, field positions, reset values and timing counts of the encoder counter.
  Assumes inclusion by bare name from any design or bench file.
*/
`ifndef MEC_PARAMS_SVH
`define MEC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MEC_OFF_CTRL 12'h000
`define MEC_OFF_STAT 12'h004
`define MEC_OFF_LEVEL 12'h008
`define MEC_SUB_CFG 4'h0
`define MEC_SUB_COUNT 4'h4
`define MEC_SUB_SNAP 4'h8
`define MEC_SUB_PRESET 4'hc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MEC_CTRL_SYNC_BIT 0
`define MEC_CTRL_RETAIN_BIT 1
`define MEC_STAT_READY_BIT 0
`define MEC_STAT_HALT_BIT 1
`define MEC_CFG_MODE_LSB 0
`define MEC_CFG_XOR_BIT 2

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define MEC_RST_RETAIN 1'b1
`define MEC_RST_XOR 1'b1
`define MEC_RST_MODE 2'h0
`define MEC_MODE_STOP 2'h0
`define MEC_MODE_UPDN 2'h1
`define MEC_MODE_PDIR 2'h2
`define MEC_MODE_QUAD 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MEC_CLK_HZ 25000000
`define MEC_DISP_STEP_MS 500
`define MEC_DISP_STEP_CYC ((`MEC_CLK_HZ / 1000) * `MEC_DISP_STEP_MS)
`define MEC_NUM_STEPS 6

`endif

// ### shared/mec_pkg.sv
/*
  Types shared by the encoder counter modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mec_pkg;

  typedef enum logic [2:0] {
    ST_LOAD_RD, ST_LOAD_WAIT, ST_LOAD_CAP, ST_IDLE, ST_SAVE, ST_HALT
  } mec_state_type;

  typedef struct packed {
    logic xr;
    logic [1:0] mode;
  } mec_cfg_type;

  typedef struct packed {
    logic z;
    logic b;
    logic a;
  } mec_pins_type;

  typedef struct packed {
    logic dp;
    logic [6:0] seg;
  } mec_digit_type;

endpackage

// ### hdl/mec_chan.sv
/*
  One encoder channel: pin synchroniser, polarity stage, counter and snapshot.
  Assumes pins are asynchronous and load/snap pulses come from the system clock.
*/
`include "mec_params.svh"

module mec_chan #(
  parameter int CW = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Encoder pins, raw
  input wire mec_pkg::mec_pins_type pins,
  // Control
  input wire mec_pkg::mec_cfg_type cfg,
  input wire logic load_en,
  input wire logic [CW-1:0] load_val,
  input wire logic snap_en,
  // State
  output logic [CW-1:0] count_r,
  output logic [CW-1:0] snap_r,
  output mec_pkg::mec_pins_type level_r
);

  logic [2:0] s1_r, s2_r, s3_r, filt_r;
  logic [2:0] lvl;
  logic rise_a, rise_b, chg_a, chg_b, up, dn;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // A change is accepted only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      filt_r <= 3'h0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        filt_r <= s3_r;
      end
    end
  end

  // Polarity applies to all three inputs at once
  assign lvl = filt_r ^ {3{cfg.xr}};

  always_ff @(posedge clk) begin
    if (rst) begin
      level_r <= '0;
    end else begin
      level_r <= lvl;
    end
  end

  // ----------------------------------------------------------------
  // Count direction
  // ----------------------------------------------------------------
  assign rise_a = lvl[0] & ~level_r.a;
  assign rise_b = lvl[1] & ~level_r.b;
  assign chg_a = lvl[0] ^ level_r.a;
  assign chg_b = lvl[1] ^ level_r.b;

  always_comb begin
    up = 1'b0;
    dn = 1'b0;
    case (cfg.mode)
      `MEC_MODE_UPDN: begin
        up = rise_a & ~rise_b;
        dn = rise_b & ~rise_a;
      end
      `MEC_MODE_PDIR: begin
        up = rise_a & ~lvl[1];
        dn = rise_a & lvl[1];
      end
      `MEC_MODE_QUAD: begin
        // Both phases moving together is illegal and dropped
        up = (chg_a ^ chg_b) & (lvl[0] ^ level_r.b);
        dn = (chg_a ^ chg_b) & ~(lvl[0] ^ level_r.b);
      end
      default: begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Counter and snapshot
  // ----------------------------------------------------------------
  // Plain modulo arithmetic; no carry is kept anywhere
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
    end else if (load_en) begin
      count_r <= load_val;
    end else if (up) begin
      count_r <= count_r + 1'b1;
    end else if (dn) begin
      count_r <= count_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      snap_r <= '0;
    end else if (snap_en) begin
      snap_r <= count_r;
    end
  end

endmodule

// ### hdl/mec_top.sv
/*
  Three-channel encoder counter with APB registers, preset store and display.
  Assumes an APB master on SYS_CLK and a nonvolatile store on the same clock
  that returns read data one cycle after it samples NVM_RE high.
*/
// Function
// - Each channel holds a 32-bit up/down count wrapping in both directions.
// - Wrapping sets no overflow or underflow flag anywhere.
// - Sync command copies live counts to snapshots; counting never pauses.
// - Host broadcasts sync so all capture together, then reads one by one.
// - Preset write stores the channel preset in nonvolatile memory.
// - At power-up each counter loads its preset from nonvolatile memory.
// - Retaining variant saves counts as presets at power-down when enabled.
// - Retention bit written 0 stops the power-down save.
// - Non-retaining variant ignores retention; start count is always the preset.
// - Counting treats A and B active-high after XOR; Z is not counted; XOR 1 recommended.
// - XOR inverts A, B and Z together.
// - Input level query reports current A, B, Z levels per channel.
// - Display cycles encoders 0, 1, 2, two steps each, six in all.
// - First step: digit with point plus upper half; second: no point, lower.
// - Points of last three digits show Z, B, A levels.
// - Two-bit count mode: stop, up/down, pulse/direction, quadrature.
`include "mec_params.svh"

module mec_top #(
  parameter int CW = 32,
  parameter int NCH = 3,
  parameter bit RETAIN = 1'b1,
  parameter int STEP_CYC = `MEC_DISP_STEP_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Encoder pins
  input wire mec_pkg::mec_pins_type [NCH-1:0] ENC_PINS,
  // Power failure warning, asynchronous
  input wire logic PWR_FAIL,
  // Nonvolatile preset store
  output logic NVM_WE,
  output logic NVM_RE,
  output logic [1:0] NVM_ADDR,
  output logic [CW-1:0] NVM_WDATA,
  input wire logic [CW-1:0] NVM_RDATA,
  // Display, digit 4 leftmost
  output mec_pkg::mec_digit_type [4:0] DISP_DIGIT
);

  mec_pkg::mec_state_type st_r;
  mec_pkg::mec_cfg_type cfg_r [NCH];
  logic [CW-1:0] cnt [NCH];
  logic [CW-1:0] snap [NCH];
  logic [CW-1:0] preset_r [NCH];
  mec_pkg::mec_pins_type lvl [NCH];
  logic [1:0] idx_r;
  logic retain_r;
  logic acc, done, wr_done, bus_ok;
  logic is_ch, hit;
  logic [1:0] ch_sel;
  logic [31:0] rd_val;
  logic sync_pls, preset_wr;
  logic [2:0] pf_sync_r;
  logic pf_filt_r, pf_prev_r, pf_rise;
  logic [31:0] tmr_r;
  logic [2:0] step_r;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      mec_chan #(.CW(CW)) u_chan (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .pins(ENC_PINS[gi]),
        .cfg(cfg_r[gi]),
        .load_en((st_r == mec_pkg::ST_LOAD_CAP) && (idx_r == 2'(gi))),
        .load_val(NVM_RDATA),
        .snap_en(sync_pls),
        .count_r(cnt[gi]),
        .snap_r(snap[gi]),
        .level_r(lvl[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign acc = PSEL & PENABLE;
  assign done = acc & PREADY;
  assign wr_done = done & PWRITE;
  // Bus waits while the preset store is being loaded or saved
  assign bus_ok = (st_r == mec_pkg::ST_IDLE) || (st_r == mec_pkg::ST_HALT);
  assign is_ch = (PADDR[11:6] == 6'h00) && (PADDR[5:4] != 2'h0) && (PADDR[1:0] == 2'h0);
  assign ch_sel = PADDR[5:4] - 2'h1;

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (PADDR == `MEC_OFF_CTRL) begin
      rd_val[`MEC_CTRL_RETAIN_BIT] = retain_r;
    end else if (PADDR == `MEC_OFF_STAT) begin
      rd_val[`MEC_STAT_READY_BIT] = (st_r == mec_pkg::ST_IDLE);
      rd_val[`MEC_STAT_HALT_BIT] = (st_r == mec_pkg::ST_HALT);
    end else if (PADDR == `MEC_OFF_LEVEL) begin
      for (int i = 0; i < NCH; i++) begin
        rd_val[3*i +: 3] = lvl[i];
      end
    end else if (is_ch && (32'(ch_sel) < NCH)) begin
      case (PADDR[3:0])
        `MEC_SUB_CFG: rd_val[2:0] = cfg_r[ch_sel];
        `MEC_SUB_COUNT: rd_val = 32'(cnt[ch_sel]);
        `MEC_SUB_SNAP: rd_val = 32'(snap[ch_sel]);
        `MEC_SUB_PRESET: rd_val = 32'(preset_r[ch_sel]);
        default: hit = 1'b0;
      endcase
    end else begin
      hit = 1'b0;
    end
  end

  // One wait state, more while the store sequencer is busy
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= acc & ~PREADY & bus_ok;
      if (acc & ~PREADY & bus_ok) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_val;
        PSLVERR <= ~hit;
      end else begin
        PRDATA <= 32'h0000_0000;
        PSLVERR <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // One write reaches every channel in the same cycle
  assign sync_pls = wr_done & hit & (PADDR == `MEC_OFF_CTRL) & PWDATA[`MEC_CTRL_SYNC_BIT];
  assign preset_wr = wr_done & hit & is_ch & (PADDR[3:0] == `MEC_SUB_PRESET);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      retain_r <= `MEC_RST_RETAIN;
    end else if (wr_done && hit && (PADDR == `MEC_OFF_CTRL)) begin
      retain_r <= PWDATA[`MEC_CTRL_RETAIN_BIT];
    end
  end

  generate
    for (gi = 0; gi < NCH; gi++) begin : g_cfg
      always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
          cfg_r[gi] <= {`MEC_RST_XOR, `MEC_RST_MODE};
        end else if (wr_done && hit && is_ch && (ch_sel == 2'(gi)) && (PADDR[3:0] == `MEC_SUB_CFG)) begin
          // Host picks 0 here for single-ended active-high encoders
          cfg_r[gi].xr <= PWDATA[`MEC_CFG_XOR_BIT];
          cfg_r[gi].mode <= PWDATA[`MEC_CFG_MODE_LSB +: 2];
        end
      end

      always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
          preset_r[gi] <= '0;
        end else if ((st_r == mec_pkg::ST_LOAD_CAP) && (idx_r == 2'(gi))) begin
          preset_r[gi] <= NVM_RDATA;
        end else if (preset_wr && (ch_sel == 2'(gi))) begin
          preset_r[gi] <= PWDATA[CW-1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Power failure detect
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pf_sync_r <= 3'h0;
      pf_filt_r <= 1'b0;
      pf_prev_r <= 1'b0;
    end else begin
      pf_sync_r <= {pf_sync_r[1:0], PWR_FAIL};
      if (pf_sync_r[1] == pf_sync_r[2]) begin
        pf_filt_r <= pf_sync_r[2];
      end
      pf_prev_r <= pf_filt_r;
    end
  end

  assign pf_rise = pf_filt_r & ~pf_prev_r;

  // ----------------------------------------------------------------
  // Preset store sequencer
  // ----------------------------------------------------------------
  // Reset stands in for power-up: presets are read back before counting
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_r <= mec_pkg::ST_LOAD_RD;
      idx_r <= 2'h0;
      NVM_WE <= 1'b0;
      NVM_RE <= 1'b0;
      NVM_ADDR <= 2'h0;
      NVM_WDATA <= '0;
    end else begin
      NVM_WE <= 1'b0;
      NVM_RE <= 1'b0;
      case (st_r)
        mec_pkg::ST_LOAD_RD: begin
          NVM_RE <= 1'b1;
          NVM_ADDR <= idx_r;
          st_r <= mec_pkg::ST_LOAD_WAIT;
        end
        mec_pkg::ST_LOAD_WAIT: begin
          st_r <= mec_pkg::ST_LOAD_CAP;
        end
        mec_pkg::ST_LOAD_CAP: begin
          if (32'(idx_r) == NCH - 1) begin
            idx_r <= 2'h0;
            st_r <= mec_pkg::ST_IDLE;
          end else begin
            idx_r <= idx_r + 2'h1;
            st_r <= mec_pkg::ST_LOAD_RD;
          end
        end
        mec_pkg::ST_IDLE: begin
          // A failing supply outranks a preset write in the same cycle
          if (pf_rise) begin
            idx_r <= 2'h0;
            st_r <= (RETAIN && retain_r) ? mec_pkg::ST_SAVE : mec_pkg::ST_HALT;
          end else if (preset_wr) begin
            NVM_WE <= 1'b1;
            NVM_ADDR <= ch_sel;
            NVM_WDATA <= PWDATA[CW-1:0];
          end
        end
        mec_pkg::ST_SAVE: begin
          NVM_WE <= 1'b1;
          NVM_ADDR <= idx_r;
          NVM_WDATA <= cnt[idx_r];
          if (32'(idx_r) == NCH - 1) begin
            st_r <= mec_pkg::ST_HALT;
          end else begin
            idx_r <= idx_r + 2'h1;
          end
        end
        mec_pkg::ST_HALT: begin
          // Store is left alone until the next reset
          st_r <= mec_pkg::ST_HALT;
        end
        default: begin
          st_r <= mec_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Display sequencer
  // ----------------------------------------------------------------
  function automatic logic [6:0] seg7(input logic [3:0] v);
    case (v)
      4'h0: seg7 = 7'h3f;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5b;
      4'h3: seg7 = 7'h4f;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6d;
      4'h6: seg7 = 7'h7d;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7f;
      4'h9: seg7 = 7'h6f;
      4'ha: seg7 = 7'h77;
      4'hb: seg7 = 7'h7c;
      4'hc: seg7 = 7'h39;
      4'hd: seg7 = 7'h5e;
      4'he: seg7 = 7'h79;
      default: seg7 = 7'h71;
    endcase
  endfunction

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      tmr_r <= 32'h0000_0000;
      step_r <= 3'h0;
    end else if (tmr_r >= 32'(STEP_CYC - 1)) begin
      tmr_r <= 32'h0000_0000;
      step_r <= (step_r == 3'(`MEC_NUM_STEPS - 1)) ? 3'h0 : step_r + 3'h1;
    end else begin
      tmr_r <= tmr_r + 32'h0000_0001;
    end
  end

  // Channel is step / 2; even steps carry the upper half
  logic [1:0] d_ch;
  logic [15:0] d_half;
  mec_pkg::mec_pins_type d_lvl;

  always_comb begin
    d_ch = step_r[2:1];
    d_half = step_r[0] ? cnt[d_ch][15:0] : cnt[d_ch][31:16];
    d_lvl = lvl[d_ch];
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      DISP_DIGIT <= '0;
    end else begin
      DISP_DIGIT[4] <= {~step_r[0], seg7({2'h0, d_ch})};
      DISP_DIGIT[3] <= {1'b0, seg7(d_half[15:12])};
      DISP_DIGIT[2] <= {d_lvl.z, seg7(d_half[11:8])};
      DISP_DIGIT[1] <= {d_lvl.b, seg7(d_half[7:4])};
      DISP_DIGIT[0] <= {d_lvl.a, seg7(d_half[3:0])};
    end
  end

endmodule

// ### sim/mec_nvm_model.sv
/*
  Behavioural nonvolatile preset store, one word per channel.
  Assumes strobes on the rising clock edge; contents survive reset.
*/
module mec_nvm_model #(
  parameter logic [95:0] INIT = 96'h0
) (
  // Clock
  input wire logic clk,
  // Store port
  input wire logic we,
  input wire logic re,
  input wire logic [1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [3];
  initial begin
    for (int i = 0; i < 3; i++) mem[i] = INIT[32*i +: 32];
    rdata = ~INIT[31:0];
  end
  always @(posedge clk) begin
    if (we && addr != 2'h3) mem[addr] <= wdata;
    // Read data held until the next read strobe
    if (re) rdata <= mem[addr];
  end
endmodule

// ### sim/mec_top_asserts.sv
/*
  Checker for the encoder counter top: bus answer, store strobes, display pace.
  Assumes binding to mec_top; power fail stays raised until the next reset.
*/
module mec_top_asserts #(
  parameter int CW = 32,
  parameter int NCH = 3,
  parameter bit RETAIN = 1'b1,
  parameter int STEP_CYC = 8
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Power and store
  input wire logic PWR_FAIL,
  input wire logic NVM_WE,
  input wire logic NVM_RE,
  input wire logic [1:0] NVM_ADDR,
  input wire logic [CW-1:0] NVM_WDATA,
  // Display
  input wire mec_pkg::mec_digit_type [4:0] DISP_DIGIT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  logic pf_seen_r;
  logic dp_q_r;
  logic [1:0] seen_r;
  int step_cnt_r;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) pf_seen_r <= 1'b0;
    else if (PWR_FAIL) pf_seen_r <= 1'b1;
  end
  // First step after reset may be short, so pace is judged from the third change
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      dp_q_r <= 1'b0;
      seen_r <= 2'h0;
      step_cnt_r <= 0;
    end else begin
      dp_q_r <= DISP_DIGIT[4].dp;
      step_cnt_r <= (DISP_DIGIT[4].dp != dp_q_r) ? 1 : step_cnt_r + 1;
      if (DISP_DIGIT[4].dp != dp_q_r && seen_r != 2'h2) seen_r <= seen_r + 2'h1;
    end
  end
  a_ready_single: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  a_ready_cause: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && PENABLE))
    else $error("ready without access");
  a_err_decode: assert property (PREADY |-> PSLVERR == (PADDR >= 12'h040 || PADDR == 12'h00c))
    else $error("wrong error answer");
  a_idle_quiet: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR) else $error("answer outside ready");
  a_preset_store: assert property (PREADY && PWRITE && !PSLVERR && PADDR[3:0] == 4'hc && !pf_seen_r
    && !PWR_FAIL |=> NVM_WE && NVM_ADDR == $past(PADDR[5:4]) - 2'h1 && NVM_WDATA == $past(PWDATA))
    else $error("preset not sent to store");
  a_save_order: assert property ($rose(NVM_WE) && pf_seen_r |-> NVM_ADDR == 2'h0
    ##1 NVM_WE && NVM_ADDR == 2'h1 ##1 NVM_WE && NVM_ADDR == 2'h2 ##1 !NVM_WE) else $error("bad save sequence");
  a_boot_read: assert property ($fell(SYS_RST) |-> ##[0:2] (NVM_RE && NVM_ADDR == 2'h0))
    else $error("no preset read after reset");
  a_read_strobe: assert property (NVM_RE |=> !NVM_RE && !NVM_WE) else $error("read strobe too long");
  a_disp_pace: assert property (seen_r == 2'h2 && DISP_DIGIT[4].dp != dp_q_r |-> step_cnt_r == STEP_CYC)
    else $error("display step length wrong");
  c_preset: cover property (NVM_WE && !pf_seen_r);
  c_save: cover property (NVM_WE && pf_seen_r);
  c_error: cover property (PSLVERR);
endmodule

bind mec_top mec_top_asserts #(.CW(CW), .NCH(NCH), .RETAIN(RETAIN), .STEP_CYC(STEP_CYC)) chk_u (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PWR_FAIL(PWR_FAIL),
  .NVM_WE(NVM_WE), .NVM_RE(NVM_RE), .NVM_ADDR(NVM_ADDR), .NVM_WDATA(NVM_WDATA), .DISP_DIGIT(DISP_DIGIT));

// ### sim/mec_top_tb.sv
/*
  Self-checking bench for the encoder counter: counting modes, sync, presets, power fail, display.
  Assumes mec_top with a short display step and the store model on the same clock.
*/
module mec_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STEP = 8;
  localparam logic [95:0] INIT = {32'h1234_5678, 32'h0000_0000, 32'hffff_fffe};
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pwr_fail = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, nvm_wdata, nvm_rdata;
  logic pready, pslverr, er, nvm_we, nvm_re;
  logic [1:0] nvm_addr;
  mec_pkg::mec_pins_type [2:0] enc = '0;
  mec_pkg::mec_digit_type [4:0] disp;
  logic [31:0] prdata_p, nvm_wdata_p, nvm_rdata_p;
  logic pready_p, pslverr_p, nvm_we_p, nvm_re_p;
  logic [1:0] nvm_addr_p;
  mec_pkg::mec_digit_type [4:0] disp_p;
  logic [31:0] cnt_e [3];
  int miscompares = 0, samples_checked = 0;
  always #20 sys_clk = ~sys_clk;

  mec_top #(.STEP_CYC(STEP)) dut_u (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ENC_PINS(enc), .PWR_FAIL(pwr_fail), .NVM_WE(nvm_we), .NVM_RE(nvm_re), .NVM_ADDR(nvm_addr),
    .NVM_WDATA(nvm_wdata), .NVM_RDATA(nvm_rdata), .DISP_DIGIT(disp));
  mec_nvm_model #(.INIT(INIT)) nvm_u (.clk(sys_clk), .we(nvm_we), .re(nvm_re), .addr(nvm_addr),
    .wdata(nvm_wdata), .rdata(nvm_rdata));
  // Non-retaining variant on the same stimulus; only its store is judged
  mec_top #(.STEP_CYC(STEP), .RETAIN(1'b0)) dut_plain_u (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata_p), .PREADY(pready_p),
    .PSLVERR(pslverr_p), .ENC_PINS(enc), .PWR_FAIL(pwr_fail), .NVM_WE(nvm_we_p), .NVM_RE(nvm_re_p),
    .NVM_ADDR(nvm_addr_p), .NVM_WDATA(nvm_wdata_p), .NVM_RDATA(nvm_rdata_p), .DISP_DIGIT(disp_p));
  mec_nvm_model #(.INIT(INIT)) nvm_plain_u (.clk(sys_clk), .we(nvm_we_p), .re(nvm_re_p), .addr(nvm_addr_p),
    .wdata(nvm_wdata_p), .rdata(nvm_rdata_p));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Idle cycle after each transfer keeps one assignment per signal per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    er = pslverr;
    if (n >= 100) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic pin(input int ch, input logic [2:0] zba);
    enc[ch] <= zba;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    pwr_fail <= 1'b0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++) rdchk("start count", 12'h014 + 12'(16 * i), cnt_e[i]);
  endtask

  task automatic t_count();
    rdchk("status", 12'h004, 32'h1);
    apb(1'b1, 12'h010, 32'h3);
    pin(0, 3'b001);
    pin(0, 3'b011);
    rdchk("wrap up", 12'h014, 32'h0);
    pin(0, 3'b010);
    pin(0, 3'b000);
    pin(0, 3'b011);
    pin(0, 3'b000);
    rdchk("double step", 12'h014, 32'h2);
    pin(0, 3'b010);
    pin(0, 3'b011);
    pin(0, 3'b001);
    rdchk("wrap down", 12'h014, 32'hffff_ffff);
    pin(0, 3'b000);
    rdchk("no flag", 12'h004, 32'h1);
    apb(1'b1, 12'h020, 32'h0);
    apb(1'b1, 12'h020, 32'h1);
    pin(1, 3'b001);
    pin(1, 3'b000);
    pin(1, 3'b001);
    pin(1, 3'b000);
    pin(1, 3'b010);
    pin(1, 3'b000);
    rdchk("up down mode", 12'h024, 32'h1);
    apb(1'b1, 12'h020, 32'h2);
    pin(1, 3'b010);
    pin(1, 3'b011);
    pin(1, 3'b000);
    rdchk("direction mode", 12'h024, 32'h0);
    apb(1'b1, 12'h020, 32'h0);
    pin(1, 3'b001);
    pin(1, 3'b000);
    rdchk("stopped", 12'h024, 32'h0);
    cnt_e[0] = 32'hffff_fffe;
    $display("test count done");
  endtask

  task automatic t_level();
    int hits, bad, up_hits, lo_hits;
    logic [2:0] p;
    hits = 0;
    bad = 0;
    up_hits = 0;
    lo_hits = 0;
    pin(2, 3'b101);
    rdchk("levels inverted", 12'h008, 32'h080);
    apb(1'b1, 12'h030, 32'h0);
    pin(2, 3'b101);
    rdchk("levels plain", 12'h008, 32'h140);
    for (int i = 0; i < 6 * STEP; i++) begin
      @(posedge sys_clk);
      p = {disp[2].dp, disp[1].dp, disp[0].dp};
      if (p === 3'b101) hits++;
      else if (p !== 3'b000) bad++;
      // Channel 2 holds 12345678 with Z and A high
      if (disp === 40'hdb_06_db_4f_e6) up_hits++;
      if (disp === 40'h5b_6d_fd_07_ff) lo_hits++;
    end
    chk("upper half shown", 32'(STEP), 32'(up_hits));
    chk("lower half shown", 32'(STEP), 32'(lo_hits));
    chk("level points shown", 32'(2 * STEP), 32'(hits));
    chk("level points wrong", 32'h0, 32'(bad));
    $display("test level done");
  endtask

  task automatic t_sync();
    apb(1'b1, 12'h000, 32'h3);
    for (int i = 0; i < 3; i++) rdchk("snapshot", 12'h018 + 12'(16 * i), cnt_e[i]);
    pin(0, 3'b001);
    rdchk("live count", 12'h014, 32'hffff_ffff);
    rdchk("held snapshot", 12'h018, 32'hffff_fffe);
    apb(1'b1, 12'h014, 32'h0);
    rdchk("read only count", 12'h014, 32'hffff_ffff);
    rdchk("sync clears", 12'h000, 32'h2);
    apb(1'b0, 12'h00c, 32'h0);
    chk("hole error", 32'h1, 32'(er));
    apb(1'b1, 12'h040, 32'h0);
    chk("range error", 32'h1, 32'(er));
    apb(1'b1, 12'h03c, 32'ha5a5_0f0f);
    rdchk("preset back", 12'h03c, 32'ha5a5_0f0f);
    chk("preset stored", 32'ha5a5_0f0f, nvm_u.mem[2]);
    cnt_e[0] = 32'hffff_ffff;
    $display("test sync done");
  endtask

  task automatic t_power();
    pwr_fail <= 1'b1;
    repeat (20) @(posedge sys_clk);
    for (int i = 0; i < 3; i++) chk("saved count", cnt_e[i], nvm_u.mem[i]);
    chk("plain variant kept preset", 32'hffff_fffe, nvm_plain_u.mem[0]);
    rdchk("halted", 12'h004, 32'h2);
    do_reset();
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h010, 32'h3);
    pin(0, 3'b011);
    rdchk("moved", 12'h014, 32'h0);
    pwr_fail <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk("not saved", 32'hffff_ffff, nvm_u.mem[0]);
    do_reset();
    $display("test power done");
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 3; i++) cnt_e[i] = INIT[32*i +: 32];
    do_reset();
    t_count();
    t_level();
    t_sync();
    t_power();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end
endmodule
